// *** orre_exec_map.vh ***
// Opcodes, field positions and reset values of the OR/rotate/return unit
`ifndef ORRE_EXEC_MAP_VH
`define ORRE_EXEC_MAP_VH

// ============================================================
// Instruction word layout
`define ORRE_WORD_W        16
`define ORRE_OP8_HI        15
`define ORRE_OP8_LO        8
`define ORRE_OP9_HI        15
`define ORRE_OP9_LO        7
`define ORRE_IMM_HI        7
`define ORRE_IMM_LO        4
`define ORRE_WSEL_HI       3
`define ORRE_WSEL_LO       0
`define ORRE_ADDR_HI       6
`define ORRE_ADDR_LO       0

// ============================================================
// Opcode patterns
`define ORRE_OP8_OR_ACC    8'h3E
`define ORRE_OP8_OR_WB     8'h3F
`define ORRE_OP9_OR_MEM_WB 9'h076
`define ORRE_OP9_ROT_LEFT  9'h099
`define ORRE_OP9_ROT_RIGHT 9'h09B
`define ORRE_RETURN_WORD   16'h0100

// ============================================================
// Nibble bit positions and reset values
`define ORRE_NIB_MSB       3
`define ORRE_NIB_LSB       0
`define ORRE_NIB_ZERO      4'h0
`define ORRE_ACC_RESET     4'h0
`define ORRE_PC_RESET      11'h000
`define ORRE_ADDR_RESET    7'h00
`define ORRE_WSEL_RESET    4'h0
`define ORRE_FLAG_RESET    1'b0

`endif

// *** orre_execute.v ***
// Decode and execute unit for OR, rotate-through-carry and return
//
// Behaviour
// - Top byte 00111110 decodes OR immediate into accumulator
// - Accumulator gets register OR immediate; register kept
// - Top nine bits 001110110 decode OR memory write-back
// - Memory OR accumulator goes to memory and accumulator
// - Register OR immediate to register and accumulator
// - Top nine bits 010011001 decode rotate left
// - Rotate left through carry, write memory and accumulator
// - Top nine bits 010011011 decode rotate right
// - Rotate right through carry, write memory and accumulator
// - Fixed return word executes in one cycle
// - Return reloads all program counter bits from stack
`timescale 1ns/100ps
`include "orre_exec_map.vh"

module orre_execute #(
    parameter PC_W   = 11,
    parameter ADDR_W = 7,
    parameter NIB_W  = 4
) (
    input  wire              clock,
    input  wire              rst_n,
    input  wire              clock_enable,
    input  wire              instr_valid,
    input  wire [15:0]       instr_word,
    input  wire [NIB_W-1:0]  mem_read_data,
    input  wire [NIB_W-1:0]  work_read_data,
    input  wire [PC_W-1:0]   stack_top,
    output reg  [ADDR_W-1:0] mem_address,
    output reg               mem_write_enable,
    output reg  [NIB_W-1:0]  mem_write_data,
    output reg  [3:0]        work_select,
    output reg               work_write_enable,
    output reg  [NIB_W-1:0]  work_write_data,
    output reg  [NIB_W-1:0]  accumulator,
    output reg               carry_flag,
    output reg               zero_flag,
    output reg  [PC_W-1:0]   program_counter,
    output reg               pc_load,
    output reg               stack_pop,
    output reg               instr_done,
    output reg               instr_unknown
);

    // ============================================================
    // One-hot operation codes
    localparam [6:0] OP_NONE   = 7'h01;
    localparam [6:0] OP_OR_ACC = 7'h02;
    localparam [6:0] OP_OR_WB  = 7'h04;
    localparam [6:0] OP_OR_MEM = 7'h08;
    localparam [6:0] OP_ROT_L  = 7'h10;
    localparam [6:0] OP_ROT_R  = 7'h20;
    localparam [6:0] OP_RETURN = 7'h40;

    // ============================================================
    // Opcode field slices
    function [7:0] top_byte;
        input [15:0] word;
        begin
            top_byte = word[`ORRE_OP8_HI:`ORRE_OP8_LO];
        end
    endfunction

    function [8:0] top_nine;
        input [15:0] word;
        begin
            top_nine = word[`ORRE_OP9_HI:`ORRE_OP9_LO];
        end
    endfunction

    // ============================================================
    // Decoder
    // Return is checked first: its full word is fixed, so no
    // operand field can alias it into another pattern.
    function [6:0] decode_op;
        input [15:0] word;
        begin
            if (word == `ORRE_RETURN_WORD) begin
                decode_op = OP_RETURN;
            end else if (top_byte(word) == `ORRE_OP8_OR_ACC) begin
                decode_op = OP_OR_ACC;
            end else if (top_byte(word) == `ORRE_OP8_OR_WB) begin
                decode_op = OP_OR_WB;
            end else if (top_nine(word) == `ORRE_OP9_OR_MEM_WB) begin
                decode_op = OP_OR_MEM;
            end else if (top_nine(word) == `ORRE_OP9_ROT_LEFT) begin
                decode_op = OP_ROT_L;
            end else if (top_nine(word) == `ORRE_OP9_ROT_RIGHT) begin
                decode_op = OP_ROT_R;
            end else begin
                decode_op = OP_NONE;
            end
        end
    endfunction

    function is_zero;
        input [NIB_W-1:0] value;
        begin
            is_zero = (value == `ORRE_NIB_ZERO);
        end
    endfunction

    // ============================================================
    // Field extraction
    wire [6:0]        op_code;
    wire              is_return;
    wire [NIB_W-1:0]  immediate_field;
    wire [3:0]        working_register_select;
    wire [ADDR_W-1:0] memory_address_field;

    assign op_code         = decode_op(instr_word);
    assign is_return       = (instr_word == `ORRE_RETURN_WORD);
    assign immediate_field = instr_word[`ORRE_IMM_HI:`ORRE_IMM_LO];
    assign working_register_select =
        instr_word[`ORRE_WSEL_HI:`ORRE_WSEL_LO];
    assign memory_address_field =
        instr_word[`ORRE_ADDR_HI:`ORRE_ADDR_LO];

    // ============================================================
    // Operand networks
    // Rotates are built a bit at a time so the carry entry points
    // follow NIB_W; the carry exit bits are the fixed ORRE_NIB_MSB and ORRE_NIB_LSB.
    wire [NIB_W-1:0] or_immediate_result;
    wire [NIB_W-1:0] or_memory_result;
    wire [NIB_W-1:0] rotate_left_result;
    wire [NIB_W-1:0] rotate_right_result;

    assign or_immediate_result = work_read_data | immediate_field;
    assign or_memory_result    = mem_read_data | accumulator;

    genvar bit_index;
    generate
        for (bit_index = 0; bit_index < NIB_W;
             bit_index = bit_index + 1) begin : g_rotate
            if (bit_index == `ORRE_NIB_LSB) begin : g_left_in
                assign rotate_left_result[bit_index] = carry_flag;
            end else begin : g_left_shift
                assign rotate_left_result[bit_index] =
                    mem_read_data[bit_index-1];
            end
            if (bit_index == NIB_W-1) begin : g_right_in
                assign rotate_right_result[bit_index] = carry_flag;
            end else begin : g_right_shift
                assign rotate_right_result[bit_index] =
                    mem_read_data[bit_index+1];
            end
        end
    endgenerate

    // ============================================================
    // Result computation
    reg [NIB_W-1:0] next_result;
    reg             next_carry;
    reg             next_acc_we;
    reg             next_mem_we;
    reg             next_work_we;
    reg             next_flags_we;
    reg             next_carry_we;
    reg             next_unknown;

    always @* begin
        next_result   = `ORRE_NIB_ZERO;
        next_carry    = carry_flag;
        next_acc_we   = 1'b0;
        next_mem_we   = 1'b0;
        next_work_we  = 1'b0;
        next_flags_we = 1'b0;
        next_carry_we = 1'b0;
        next_unknown  = 1'b0;
        if (!is_return) begin
            case (op_code)
                OP_OR_ACC: begin
                    // Register left alone, only accumulator and zero flag written
                    next_result   = or_immediate_result;
                    next_acc_we   = 1'b1;
                    next_flags_we = 1'b1;
                end
                OP_OR_WB: begin
                    // Same fields as the accumulator-only form
                    next_result   = or_immediate_result;
                    next_acc_we   = 1'b1;
                    next_work_we  = 1'b1;
                    next_flags_we = 1'b1;
                end
                OP_OR_MEM: begin
                    next_result   = or_memory_result;
                    next_acc_we   = 1'b1;
                    next_mem_we   = 1'b1;
                    next_flags_we = 1'b1;
                end
                OP_ROT_L: begin
                    next_result   = rotate_left_result;
                    next_carry    = mem_read_data[`ORRE_NIB_MSB];
                    next_acc_we   = 1'b1;
                    next_mem_we   = 1'b1;
                    next_flags_we = 1'b1;
                    next_carry_we = 1'b1;
                end
                OP_ROT_R: begin
                    next_result   = rotate_right_result;
                    next_carry    = mem_read_data[`ORRE_NIB_LSB];
                    next_acc_we   = 1'b1;
                    next_mem_we   = 1'b1;
                    next_flags_we = 1'b1;
                    next_carry_we = 1'b1;
                end
                OP_NONE: begin
                    // Outside this unit's set: flag it, touch no state
                    next_unknown = 1'b1;
                end
                default: begin
                    next_unknown = 1'b1;
                end
            endcase
        end
    end

    // A word offered while the enable is low is not taken; the
    // sender must hold it until an enabled edge.
    wire step;
    assign step = clock_enable && instr_valid;

    // ============================================================
    // Architectural state: accumulator and flags
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            accumulator <= `ORRE_ACC_RESET;
            carry_flag  <= `ORRE_FLAG_RESET;
            zero_flag   <= `ORRE_FLAG_RESET;
        end else if (step) begin
            if (next_acc_we) begin
                accumulator <= next_result;
            end
            if (next_carry_we) begin
                carry_flag <= next_carry;
            end
            if (next_flags_we) begin
                zero_flag <= is_zero(next_result);
            end
        end
    end

    // ============================================================
    // Program counter and return stack
    // The counter here only mirrors the restored address; the
    // sequencer elsewhere takes it on pc_load.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            program_counter <= `ORRE_PC_RESET;
            pc_load         <= 1'b0;
            stack_pop       <= 1'b0;
        end else if (clock_enable) begin
            pc_load   <= step && is_return;
            stack_pop <= step && is_return;
            if (step && is_return) begin
                program_counter <= stack_top;
            end
        end
    end

    // ============================================================
    // Write-back ports to data memory and working registers
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_address       <= `ORRE_ADDR_RESET;
            mem_write_enable  <= 1'b0;
            mem_write_data    <= `ORRE_NIB_ZERO;
            work_select       <= `ORRE_WSEL_RESET;
            work_write_enable <= 1'b0;
            work_write_data   <= `ORRE_NIB_ZERO;
        end else if (clock_enable) begin
            mem_write_enable  <= step && next_mem_we;
            work_write_enable <= step && next_work_we;
            if (step && next_mem_we) begin
                mem_address    <= memory_address_field;
                mem_write_data <= next_result;
            end
            if (step && next_work_we) begin
                work_select     <= working_register_select;
                work_write_data <= next_result;
            end
        end
    end

    // ============================================================
    // Completion status
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            instr_done    <= 1'b0;
            instr_unknown <= 1'b0;
        end else if (clock_enable) begin
            // Every decoded instruction finishes in its own cycle
            instr_done    <= step && !next_unknown;
            instr_unknown <= step && next_unknown;
        end
    end

endmodule // orre_execute

// *** orre_execute_sva.sv ***
// Concurrent checks on the ports of the OR, rotate and return unit
`timescale 1ns/100ps
module orre_execute_sva #(
    parameter PC_W   = 11,
    parameter ADDR_W = 7,
    parameter NIB_W  = 4
) (
    input wire             clock,
    input wire             rst_n,
    input wire             clock_enable,
    input wire             instr_valid,
    input wire [15:0]      instr_word,
    input wire [NIB_W-1:0] mem_read_data,
    input wire [NIB_W-1:0] work_read_data,
    input wire [NIB_W-1:0] mem_write_data,
    input wire [NIB_W-1:0] work_write_data,
    input wire [NIB_W-1:0] accumulator,
    input wire [PC_W-1:0]  stack_top,
    input wire [PC_W-1:0]  program_counter,
    input wire             mem_write_enable,
    input wire             work_write_enable,
    input wire             carry_flag,
    input wire             zero_flag,
    input wire             pc_load,
    input wire             stack_pop,
    input wire             instr_done,
    input wire             instr_unknown
);
    wire             tk = clock_enable & instr_valid;
    wire [8:0]       top9 = instr_word[15:7];
    wire [NIB_W-1:0] imm_or = work_read_data | instr_word[7:4];
    wire [NIB_W-1:0] mem_or = mem_read_data | accumulator;
    wire [NIB_W-1:0] rot_l = {mem_read_data[2:0], carry_flag};
    wire [NIB_W-1:0] rot_r = {carry_flag, mem_read_data[3:1]};
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ============================================================
    // Results one cycle after a word is taken
    a_or_acc_only: assert property (tk && instr_word[15:8] == 8'h3E
        |=> !work_write_enable && accumulator == $past(imm_or))
        else $error("or into accumulator wrong");
    a_or_imm_wb: assert property (tk && instr_word[15:8] == 8'h3F
        |=> work_write_enable && work_write_data == $past(imm_or)
        && accumulator == work_write_data) else $error("or write-back wrong");
    a_or_mem_wb: assert property (tk && top9 == 9'h076
        |=> mem_write_enable && mem_write_data == $past(mem_or)
        && accumulator == mem_write_data) else $error("or memory wrong");
    a_rot_left: assert property (tk && top9 == 9'h099
        |=> mem_write_enable && accumulator == $past(rot_l)
        && carry_flag == $past(mem_read_data[3])) else $error("rotl wrong");
    a_rot_right: assert property (tk && top9 == 9'h09B
        |=> mem_write_data == $past(rot_r) && accumulator == mem_write_data
        && carry_flag == $past(mem_read_data[0])) else $error("rotr wrong");
    a_return_load: assert property (tk && instr_word == 16'h0100
        |=> pc_load && instr_done && program_counter == $past(stack_top)
        && $stable(accumulator)) else $error("return load wrong");
    a_pop_cause: assert property ($rose(stack_pop)
        |-> $past(tk) && $past(instr_word) == 16'h0100)
        else $error("stack pop without return");
    a_zero_match: assert property (instr_done && !pc_load
        |-> zero_flag == (accumulator == 4'h0)) else $error("zero flag wrong");
    // ============================================================
    // Freeze and foreign words
    a_freeze_hold: assert property (!clock_enable
        |=> $stable(accumulator) && $stable(pc_load)
        && $stable(program_counter)) else $error("state moved while frozen");
    a_unknown_quiet: assert property (instr_unknown
        |-> !instr_done && !pc_load && !mem_write_enable
        && !work_write_enable) else $error("unknown word had effect");
endmodule // orre_execute_sva

bind orre_execute orre_execute_sva #(.PC_W(PC_W), .ADDR_W(ADDR_W),
    .NIB_W(NIB_W)) u_sva (.*);

// *** orre_partner.sv ***
// Behavioural data memory, working registers and return stack
`timescale 1ns/100ps
module orre_partner (
    input  wire         clock,
    input  wire         clock_enable,
    input  wire         stack_pop,
    input  wire  [15:0] instr_word,
    input  wire  [6:0]  mem_address,
    input  wire  [3:0]  mem_write_data,
    input  wire  [3:0]  work_select,
    input  wire  [3:0]  work_write_data,
    input  wire         mem_write_enable,
    input  wire         work_write_enable,
    output logic [3:0]  mem_read_data,
    output logic [3:0]  work_read_data,
    output logic [10:0] stack_top
);
    logic [3:0]  mem [0:127];
    logic [3:0]  work [0:15];
    logic [10:0] stk [0:7];
    logic [2:0]  sp;
    // Pending writes forwarded: the unit expects fresh operands back to back
    always_comb begin
        mem_read_data = mem[instr_word[6:0]];
        if (mem_write_enable && mem_address == instr_word[6:0])
            mem_read_data = mem_write_data;
        work_read_data = work[instr_word[3:0]];
        if (work_write_enable && work_select == instr_word[3:0])
            work_read_data = work_write_data;
        stack_top = stk[sp - (stack_pop ? 3'h2 : 3'h1)];
    end
    // Strobes stand while frozen, so a write or pop counts per enabled edge
    always @(posedge clock) begin
        if (clock_enable && mem_write_enable)
            mem[mem_address] <= mem_write_data;
        if (clock_enable && work_write_enable)
            work[work_select] <= work_write_data;
        if (clock_enable && stack_pop)
            sp <= sp - 3'h1;
    end
endmodule // orre_partner

// *** orre_execute_tb_top.sv ***
// Self-checking bench for the OR, rotate and return unit
`timescale 1ns/100ps
module orre_execute_tb_top;
    typedef struct packed {
        logic [15:0] w;
        logic [3:0]  pre;
        logic [3:0]  acc;
        logic        cf;
        logic        zf;
    } orre_row_t;
    orre_row_t   rows [0:5];
    int          num_errors = 0;
    int          checked = 0;
    logic        clock = 1'h0;
    logic        rst_n = 1'h0;
    logic        clock_enable = 1'h1;
    logic        instr_valid = 1'h0;
    logic [15:0] instr_word = 16'h0000;
    wire  [3:0]  mem_read_data, work_read_data, mem_write_data;
    wire  [3:0]  work_write_data, accumulator, work_select;
    wire  [10:0] stack_top, program_counter;
    wire  [6:0]  mem_address;
    wire         mem_write_enable, work_write_enable, carry_flag, zero_flag;
    wire         pc_load, stack_pop, instr_done, instr_unknown;

    always #2 clock = ~clock;
    orre_execute dut (.*);
    orre_partner p (.*);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (num_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic issue(input logic [15:0] w);
        instr_valid = 1'h1;
        instr_word = w;
        @(negedge clock);
    endtask

    initial begin
        repeat (500) @(posedge clock);
        num_errors++;
        conclude;
    end
    initial begin
        rows[0] = '{16'h3EA3, 4'h1, 4'hB, 1'h0, 1'h0};
        rows[1] = '{16'h3E05, 4'h0, 4'h0, 1'h0, 1'h1};
        rows[2] = '{16'h3F52, 4'h2, 4'h7, 1'h0, 1'h0};
        rows[3] = '{16'h3B11, 4'h8, 4'hF, 1'h0, 1'h0};
        rows[4] = '{16'h4DB3, 4'h1, 4'h0, 1'h1, 1'h1};
        rows[5] = '{16'h4CA2, 4'h9, 4'h3, 1'h1, 1'h0};
        p.stk[0] = 11'h123;
        p.stk[1] = 11'h7FF;
        p.sp = 3'h2;
        repeat (4) @(negedge clock);
        rst_n = 1'h1;
        for (int i = 0; i < 6; i++) begin
            p.mem[rows[i].w[6:0]] = rows[i].pre;
            if (i < 3)
                p.work[rows[i].w[3:0]] = rows[i].pre;
            issue(rows[i].w);
            instr_valid = 1'h0;
            chk(accumulator, rows[i].acc);
            chk({carry_flag, zero_flag}, {rows[i].cf, rows[i].zf});
            @(negedge clock);
        end
        chk(p.work[3], 4'h1);
        chk(p.work[2], 4'h7);
        chk(p.mem[7'h11], 4'hF);
        chk(p.mem[7'h33], 4'h0);
        // Back to back on one nibble: second rotate must see the first
        p.mem[7'h22] = 4'hC;
        issue(16'h4CA2);
        chk(accumulator, 4'h9);
        issue(16'h4CA2);
        chk({carry_flag, accumulator}, 5'h13);
        issue(16'h0100);
        chk({pc_load, stack_pop, program_counter}, 13'h1FFF);
        issue(16'h0100);
        chk(program_counter, 11'h123);
        chk(accumulator, 4'h3);
        chk(p.mem[7'h22], 4'h3);
        // Frozen edge: word dropped, return pulses stand
        clock_enable = 1'h0;
        issue(16'h3E05);
        chk({pc_load, instr_done, accumulator}, 6'h33);
        clock_enable = 1'h1;
        issue(16'hFFFF);
        chk({instr_unknown, accumulator}, 5'h13);
        instr_valid = 1'h0;
        @(negedge clock);
        rst_n = 1'h0;
        @(negedge clock);
        chk({program_counter, accumulator}, 15'h0000);
        conclude;
    end
endmodule // orre_execute_tb_top
